//--- clock_source_pkg.sv
// Purpose: Shared constants for the clock source and pin control block
// Assumes: Byte-wide registers reached over the serial bus by command code
// Notes:   Field positions within the bytes are fixed here once
package clock_source_pkg;

    // Register offsets (serial bus command codes)
    localparam logic [7:0] VCO_MODE_OFS   = 8'h06;
    localparam logic [7:0] SRC_SEL_A_OFS  = 8'h09;
    localparam logic [7:0] PIN_FUNC_OFS   = 8'h0a;
    localparam logic [7:0] INPUT_CFG_OFS  = 8'h0b;
    localparam logic [7:0] POWER_CFG_OFS  = 8'h0c;

    // Reset values
    localparam logic [7:0] VCO_MODE_RST   = 8'he0;
    localparam logic [7:0] SRC_SEL_A_RST  = 8'h14;
    localparam logic [7:0] PIN_FUNC_RST   = 8'h00;
    localparam logic [7:0] INPUT_CFG_RST  = 8'h09;
    localparam logic [7:0] POWER_CFG_RST  = 8'h09;

    // Writable bit masks; other bits read as zero
    localparam logic [7:0] VCO_MODE_MASK  = 8'he0;
    localparam logic [7:0] SRC_SEL_A_MASK = 8'h3f;
    localparam logic [7:0] PIN_FUNC_MASK  = 8'hdc;
    localparam logic [7:0] INPUT_CFG_MASK = 8'hff;
    localparam logic [7:0] POWER_CFG_MASK = 8'h7f;

    // Field positions (low bit of each field)
    localparam int VCO_MODE_LSB    = 5;
    localparam int SRC_HI_LSB      = 3;
    localparam int SRC_LO_LSB      = 0;
    localparam int PIN0_FUNC_LSB   = 6;
    localparam int CLK_PICK_BIT    = 4;
    localparam int PIN1_FUNC_LSB   = 2;
    localparam int INPUT_TYPE_LSB  = 6;
    localparam int POWER_DOWN_BIT  = 6;

    // Switch A source codes; 5 to 7 reserved
    typedef enum logic [2:0] {
        SRC_INPUT_BYPASS = 3'b000,
        SRC_PLL1         = 3'b001,
        SRC_PLL2_PLAIN   = 3'b010,
        SRC_PLL2_SPREAD  = 3'b011,
        SRC_PLL3         = 3'b100
    } switch_a_source_t;

    // Control pin 0 functions
    localparam logic [1:0] PIN0_POWER_DOWN = 2'b00;
    localparam logic [1:0] PIN0_TEST_BYP   = 2'b01;
    localparam logic [1:0] PIN0_CLK_PICK   = 2'b10;

    // Control pin 1 functions
    localparam logic [1:0] PIN1_INACTIVE   = 2'b00;
    localparam logic [1:0] PIN1_TRISTATE   = 2'b01;

    // Input source types
    localparam logic [1:0] INPUT_CRYSTAL   = 2'b00;
    localparam logic [1:0] INPUT_TWO_SE    = 2'b01;
    localparam logic [1:0] INPUT_DIFF      = 2'b10;

    // Serial bus device address; value is arbitrary
    localparam logic [6:0] DEVICE_ADDR     = 7'h35;

endpackage : clock_source_pkg

//--- smbus_byte_slave.sv
// Purpose: Serial bus slave giving byte write and byte read by command code
// Assumes: Bus lines already filtered; sda driven low only through sdaOe
// Notes:   Writes auto-increment the command code; reads are single byte
module smbus_byte_slave
    import clock_source_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       sclLevel,
    input  wire logic       sdaLevel,
    input  wire logic [7:0] rdData,
    output logic            sdaOe,
    output logic            wrStrobe,
    output logic [7:0]      cmdCode,
    output logic [7:0]      wrData
);

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_ADDR    = 4'b0001,
        ST_ACK_ADR = 4'b0010,
        ST_CMD     = 4'b0011,
        ST_ACK_CMD = 4'b0100,
        ST_WDATA   = 4'b0101,
        ST_ACK_WR  = 4'b0110,
        ST_RDATA   = 4'b0111,
        ST_RACK    = 4'b1000
    } bus_state_t;

    bus_state_t  state_reg;
    logic        sclPrev_reg;
    logic        sdaPrev_reg;
    logic [3:0]  bitCnt_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  tx_reg;
    logic        readMode_reg;

    wire sclRise   = sclLevel & ~sclPrev_reg;
    wire sclFall   = ~sclLevel & sclPrev_reg;
    wire startSeen = sclLevel & sclPrev_reg & sdaPrev_reg & ~sdaLevel;
    wire stopSeen  = sclLevel & sclPrev_reg & ~sdaPrev_reg & sdaLevel;
    wire byteDone  = bitCnt_reg == 4'h8;
    wire addrMatch = shift_reg[7:1] == DEVICE_ADDR;
    wire receiving = state_reg == ST_ADDR || state_reg == ST_CMD
                     || state_reg == ST_WDATA;

    always_ff @(posedge core_clk) begin
        sclPrev_reg <= sclLevel;
        sdaPrev_reg <= sdaLevel;
        wrStrobe    <= 1'b0;
        if (sys_rst) begin
            state_reg    <= ST_IDLE;
            bitCnt_reg   <= 4'h0;
            shift_reg    <= 8'h00;
            tx_reg       <= 8'h00;
            readMode_reg <= 1'b0;
            sdaOe        <= 1'b0;
            cmdCode      <= 8'h00;
            wrData       <= 8'h00;
            sclPrev_reg  <= 1'b1;
            sdaPrev_reg  <= 1'b1;
        end else if (startSeen) begin
            state_reg  <= ST_ADDR;
            bitCnt_reg <= 4'h0;
            sdaOe      <= 1'b0;
        end else if (stopSeen) begin
            state_reg <= ST_IDLE;
            sdaOe     <= 1'b0;
        end else if (sclRise && receiving && !byteDone) begin
            shift_reg  <= {shift_reg[6:0], sdaLevel};
            bitCnt_reg <= bitCnt_reg + 4'h1;
        end else if (sclFall) begin
            case (state_reg)
                ST_ADDR: begin
                    if (byteDone && addrMatch) begin
                        sdaOe        <= 1'b1;
                        readMode_reg <= shift_reg[0];
                        state_reg    <= ST_ACK_ADR;
                    end else if (byteDone) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_ACK_ADR: begin
                    if (readMode_reg) begin
                        // First data bit goes out on the same falling edge
                        sdaOe      <= ~rdData[7];
                        tx_reg     <= {rdData[6:0], 1'b0};
                        bitCnt_reg <= 4'h1;
                        state_reg  <= ST_RDATA;
                    end else begin
                        sdaOe      <= 1'b0;
                        bitCnt_reg <= 4'h0;
                        state_reg  <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (byteDone) begin
                        cmdCode   <= shift_reg;
                        sdaOe     <= 1'b1;
                        state_reg <= ST_ACK_CMD;
                    end
                end
                ST_ACK_CMD: begin
                    sdaOe      <= 1'b0;
                    bitCnt_reg <= 4'h0;
                    state_reg  <= ST_WDATA;
                end
                ST_WDATA: begin
                    if (byteDone) begin
                        wrData    <= shift_reg;
                        wrStrobe  <= 1'b1;
                        sdaOe     <= 1'b1;
                        state_reg <= ST_ACK_WR;
                    end
                end
                ST_ACK_WR: begin
                    sdaOe      <= 1'b0;
                    bitCnt_reg <= 4'h0;
                    cmdCode    <= cmdCode + 8'h01;
                    state_reg  <= ST_WDATA;
                end
                ST_RDATA: begin
                    if (byteDone) begin
                        sdaOe     <= 1'b0;
                        state_reg <= ST_RACK;
                    end else begin
                        sdaOe      <= ~tx_reg[7];
                        tx_reg     <= {tx_reg[6:0], 1'b0};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end
                end
                ST_RACK: begin
                    // Only one byte per read; master is expected to stop
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule : smbus_byte_slave

//--- clock_source_and_pin_control.sv
// Purpose: Clock source selection, control pin functions and power control
// Assumes: Control pins and bus lines are asynchronous to core_clk
// Notes:   Outputs are control levels for the analog PLL and output stages
import clock_source_pkg::*;

// Behaviour
// - Per-PLL VCO mode bit, high-speed after reset, one selects high range.
// - Three-bit switch A source per divider, documented codes and defaults.
// - Spread bypass powers down PLL2 spread path and forces its output low.
// - PLL2 plain output runs and stays selectable regardless of spread bypass.
// - Pin0 function 00, pin low: PLLs, input off, outputs tri-stated.
// - Pin0 function 01, pin low: bypass PLL and dividers, PLL powered down.
// - Pin0 function 10: pin overrides clock pick, low input A, high B.
// - Pin0 power-down outranks pin1 low-state or tri-state forcing.
// - Pin1 function 00 low forces inactive level; 01 low tri-states outputs.
// - Clock pick bit selects input A or B; ignored for crystal or diff.
// - Input type field: crystal, two single-ended, differential, reserved.
// - Power-down bit one stops PLLs, input stage, tri-states outputs.
// - Register power-down outranks every pin-requested tri-state or low-state.
// - Configuration bytes are readable and writable over the serial bus.
module clock_source_and_pin_control
    import clock_source_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    input  wire logic        ctrlPinZero,
    input  wire logic        ctrlPinOne,
    input  wire logic        sscBypass,
    output logic [2:0]       vcoHighSpeed,
    output logic [17:0]      dividerSourceSel,
    output logic             pllPowerDown,
    output logic             inputStagePowerDown,
    output logic             spreadPowerDown,
    output logic             spreadForceLow,
    output logic             pll2PlainEnable,
    output logic             pllDividerBypass,
    output logic             outputsTristate,
    output logic             outputsInactive,
    output logic [1:0]       inputType,
    output logic             refInputBSel
);

    // Three-stage input filters; stage one is read only by stage two
    logic [2:0]  sclSync_reg;
    logic [2:0]  sdaSync_reg;
    logic [2:0]  pin0Sync_reg;
    logic [2:0]  pin1Sync_reg;
    logic        sclLevel_reg;
    logic        sdaLevel_reg;
    logic        pin0Level_reg;
    logic        pin1Level_reg;

    logic [7:0]  vcoMode_reg;
    logic [7:0]  srcSelA_reg;
    logic [7:0]  pinFunc_reg;
    logic [7:0]  inputCfg_reg;
    logic [7:0]  powerCfg_reg;

    logic        slaveSdaOe;
    logic        wrStrobe;
    logic [7:0]  cmdCode;
    logic [7:0]  wrData;
    logic [7:0]  rdData;

    function automatic logic agreed(input logic [2:0] s, input logic cur);
        agreed = (s[1] == s[2]) ? s[2] : cur;
    endfunction : agreed

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sclSync_reg   <= 3'h7;
            sdaSync_reg   <= 3'h7;
            pin0Sync_reg  <= 3'h7;
            pin1Sync_reg  <= 3'h7;
            sclLevel_reg  <= 1'b1;
            sdaLevel_reg  <= 1'b1;
            pin0Level_reg <= 1'b1;
            pin1Level_reg <= 1'b1;
        end else begin
            sclSync_reg   <= {sclSync_reg[1:0], sclIn};
            sdaSync_reg   <= {sdaSync_reg[1:0], sdaIn};
            pin0Sync_reg  <= {pin0Sync_reg[1:0], ctrlPinZero};
            pin1Sync_reg  <= {pin1Sync_reg[1:0], ctrlPinOne};
            sclLevel_reg  <= agreed(sclSync_reg, sclLevel_reg);
            sdaLevel_reg  <= agreed(sdaSync_reg, sdaLevel_reg);
            pin0Level_reg <= agreed(pin0Sync_reg, pin0Level_reg);
            pin1Level_reg <= agreed(pin1Sync_reg, pin1Level_reg);
        end
    end

    smbus_byte_slave busSlave (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .sclLevel (sclLevel_reg),
        .sdaLevel (sdaLevel_reg),
        .rdData   (rdData),
        .sdaOe    (slaveSdaOe),
        .wrStrobe (wrStrobe),
        .cmdCode  (cmdCode),
        .wrData   (wrData)
    );

    // Register write decode
    wire wrVco   = wrStrobe && cmdCode == VCO_MODE_OFS;
    wire wrSrcA  = wrStrobe && cmdCode == SRC_SEL_A_OFS;
    wire wrPin   = wrStrobe && cmdCode == PIN_FUNC_OFS;
    wire wrInput = wrStrobe && cmdCode == INPUT_CFG_OFS;
    wire wrPower = wrStrobe && cmdCode == POWER_CFG_OFS;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            vcoMode_reg  <= VCO_MODE_RST;
            srcSelA_reg  <= SRC_SEL_A_RST;
            pinFunc_reg  <= PIN_FUNC_RST;
            inputCfg_reg <= INPUT_CFG_RST;
            powerCfg_reg <= POWER_CFG_RST;
        end else begin
            if (wrVco)
                vcoMode_reg  <= wrData & VCO_MODE_MASK;
            if (wrSrcA)
                srcSelA_reg  <= wrData & SRC_SEL_A_MASK;
            if (wrPin)
                pinFunc_reg  <= wrData & PIN_FUNC_MASK;
            if (wrInput)
                inputCfg_reg <= wrData & INPUT_CFG_MASK;
            if (wrPower)
                powerCfg_reg <= wrData & POWER_CFG_MASK;
        end
    end

    // Read mux; unmapped codes read zero
    assign rdData = (cmdCode == VCO_MODE_OFS)  ? vcoMode_reg  :
                    (cmdCode == SRC_SEL_A_OFS) ? srcSelA_reg  :
                    (cmdCode == PIN_FUNC_OFS)  ? pinFunc_reg  :
                    (cmdCode == INPUT_CFG_OFS) ? inputCfg_reg :
                    (cmdCode == POWER_CFG_OFS) ? powerCfg_reg :
                    8'h00;

    // Field extraction
    wire [1:0] pinZeroFunc  = pinFunc_reg[PIN0_FUNC_LSB +: 2];
    wire [1:0] pinOneFunc   = pinFunc_reg[PIN1_FUNC_LSB +: 2];
    wire       clockPickReg = pinFunc_reg[CLK_PICK_BIT];
    wire [1:0] typeField    = inputCfg_reg[INPUT_TYPE_LSB +: 2];
    wire       regPowerDown = powerCfg_reg[POWER_DOWN_BIT];
    wire       pin0Low      = ~pin0Level_reg;
    wire       pin1Low      = ~pin1Level_reg;

    // Divider sources: P0,P1 in byte 9, P2,P3 in byte 11, P4,P5 in byte 12
    wire [17:0] srcNext = {powerCfg_reg[SRC_LO_LSB +: 3],
                           powerCfg_reg[SRC_HI_LSB +: 3],
                           inputCfg_reg[SRC_LO_LSB +: 3],
                           inputCfg_reg[SRC_HI_LSB +: 3],
                           srcSelA_reg[SRC_LO_LSB +: 3],
                           srcSelA_reg[SRC_HI_LSB +: 3]};

    // Power-down from either source; register one outranks everything
    wire pinPowerDown = pin0Low && pinZeroFunc == PIN0_POWER_DOWN;
    wire anyPowerDown = regPowerDown | pinPowerDown;
    wire testBypass   = !regPowerDown && pin0Low
                        && pinZeroFunc == PIN0_TEST_BYP;

    // Pin 1 only acts when no power-down is in force
    wire pin1Tristate = !anyPowerDown && pin1Low
                        && pinOneFunc == PIN1_TRISTATE;
    wire pin1Inactive = !anyPowerDown && pin1Low
                        && pinOneFunc == PIN1_INACTIVE;

    // Clock pick only matters for two single-ended inputs
    wire pickSource   = (pinZeroFunc == PIN0_CLK_PICK) ? pin0Level_reg
                                                       : clockPickReg;
    wire pickB        = (typeField == INPUT_TWO_SE) && pickSource;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sdaOut              <= 1'b0;
            sdaOe               <= 1'b0;
            vcoHighSpeed        <= 3'h7;
            dividerSourceSel    <= 18'h00000;
            pllPowerDown        <= 1'b0;
            inputStagePowerDown <= 1'b0;
            spreadPowerDown     <= 1'b0;
            spreadForceLow      <= 1'b0;
            pll2PlainEnable     <= 1'b0;
            pllDividerBypass    <= 1'b0;
            outputsTristate     <= 1'b0;
            outputsInactive     <= 1'b0;
            inputType           <= INPUT_CRYSTAL;
            refInputBSel        <= 1'b0;
        end else begin
            sdaOut              <= 1'b0;
            sdaOe               <= slaveSdaOe;
            vcoHighSpeed        <= vcoMode_reg[VCO_MODE_LSB +: 3];
            dividerSourceSel    <= srcNext;
            pllPowerDown        <= anyPowerDown | testBypass;
            inputStagePowerDown <= anyPowerDown;
            spreadPowerDown     <= sscBypass | anyPowerDown;
            spreadForceLow      <= sscBypass;
            // Plain PLL2 path ignores spread bypass entirely
            pll2PlainEnable     <= ~(anyPowerDown | testBypass);
            pllDividerBypass    <= testBypass;
            outputsTristate     <= anyPowerDown | pin1Tristate;
            outputsInactive     <= pin1Inactive;
            inputType           <= typeField;
            refInputBSel        <= pickB;
        end
    end

endmodule : clock_source_and_pin_control

//--- smbus_host_model.sv
// Purpose: Bus host standing outside the clock source block
// Assumes: sda has a pull-up; scl is driven by this host alone
// Notes:   Each bit's scl high phase spans HALF core clocks, a start's twice that, a low phase up to twice HALF, above the filter need
module smbus_host_model
    import clock_source_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic sdaLine,
    output logic      sclOut,
    output logic      sdaRel
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 10;

    initial begin
        sclOut = 1'b1;
        sdaRel = 1'b1;
    end

    task automatic half_wait();
        repeat (HALF) @(negedge core_clk);
    endtask : half_wait

    // Sampled late in the high phase so device drive has settled
    task automatic clock_bit(input logic b, output logic seen);
        sdaRel = b;
        half_wait();
        sclOut = 1'b1;
        half_wait();
        seen = sdaLine;
        sclOut = 1'b0;
        half_wait();
    endtask : clock_bit

    task automatic start_cond();
        sdaRel = 1'b1;
        half_wait();
        sclOut = 1'b1;
        half_wait();
        sdaRel = 1'b0;
        half_wait();
        sclOut = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        sdaRel = 1'b0;
        half_wait();
        sclOut = 1'b1;
        half_wait();
        sdaRel = 1'b1;
        half_wait();
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
        clock_bit(1'b1, s);
        ack = !s;
    endtask : send_byte

    task automatic bus_write(input logic [6:0] addr, input logic [7:0] cmd,
                             input logic [7:0] d [$], output logic ok);
        logic a;
        start_cond();
        send_byte({addr, 1'b0}, ok);
        send_byte(cmd, a);
        ok = ok & a;
        foreach (d[i]) begin
            send_byte(d[i], a);
            ok = ok & a;
        end
        stop_cond();
    endtask : bus_write

    task automatic bus_read(input logic [7:0] cmd,
                            output logic [7:0] data);
        logic a;
        start_cond();
        send_byte({DEVICE_ADDR, 1'b0}, a);
        send_byte(cmd, a);
        start_cond();
        send_byte({DEVICE_ADDR, 1'b1}, a);
        for (int i = 7; i >= 0; i--) clock_bit(1'b1, data[i]);
        clock_bit(1'b1, a);
        stop_cond();
    endtask : bus_read
endmodule : smbus_host_model

//--- clock_source_props.sv
// Purpose: Port-level checks of the clock source control block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Pin latency bounds allow for the input filters
module clock_source_chk
    import clock_source_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        ctrlPinZero,
    input wire logic        ctrlPinOne,
    input wire logic        sscBypass,
    input wire logic [2:0]  vcoHighSpeed,
    input wire logic [17:0] dividerSourceSel,
    input wire logic        pllPowerDown,
    input wire logic        inputStagePowerDown,
    input wire logic        spreadForceLow,
    input wire logic        pll2PlainEnable,
    input wire logic        pllDividerBypass,
    input wire logic        outputsTristate,
    input wire logic        outputsInactive,
    input wire logic [1:0]  inputType,
    input wire logic        refInputBSel
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] relCnt_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Edges since reset release, saturating
    always_ff @(posedge core_clk) begin
        if (sys_rst) relCnt_reg <= 3'h0;
        else if (relCnt_reg != 3'h7) relCnt_reg <= relCnt_reg + 3'h1;
    end

    property p_vco_reset;
        relCnt_reg == 3'h1 |-> vcoHighSpeed == 3'h7;
    endproperty
    a_vco_reset: assert property (p_vco_reset)
        else $error("vco mode not high after reset");
    property p_div_reset;
        relCnt_reg == 3'h3 |-> dividerSourceSel == 18'h09262;
    endproperty
    a_div_reset: assert property (p_div_reset)
        else $error("divider sources not at defaults");
    property p_spread_low;
        sscBypass [*6] |-> spreadForceLow;
    endproperty
    a_spread_low: assert property (p_spread_low)
        else $error("spread output not held low");
    property p_plain_on;
        !pllPowerDown [*4] |-> pll2PlainEnable;
    endproperty
    a_plain_on: assert property (p_plain_on)
        else $error("plain output stopped");
    property p_pd_outputs;
        inputStagePowerDown |-> pllPowerDown && outputsTristate;
    endproperty
    a_pd_outputs: assert property (p_pd_outputs)
        else $error("power-down without tri-state");
    property p_pd_masks;
        inputStagePowerDown |-> !outputsInactive && !pllDividerBypass;
    endproperty
    a_pd_masks: assert property (p_pd_masks)
        else $error("power-down did not win");
    property p_bypass;
        pllDividerBypass |-> pllPowerDown && !inputStagePowerDown;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("test bypass power state wrong");
    property p_pin0_idle;
        ctrlPinZero [*8] |-> !pllDividerBypass;
    endproperty
    a_pin0_idle: assert property (p_pin0_idle)
        else $error("bypass with pin 0 high");
    property p_pin1_idle;
        ctrlPinOne [*8] |-> !outputsInactive && !$rose(outputsInactive);
    endproperty
    a_pin1_idle: assert property (p_pin1_idle)
        else $error("inactive level with pin 1 high");
    property p_ref_sel;
        refInputBSel |-> inputType == INPUT_TWO_SE;
    endproperty
    a_ref_sel: assert property (p_ref_sel)
        else $error("input B chosen outside two-input mode");
endmodule : clock_source_chk

bind clock_source_and_pin_control clock_source_chk u_chk (.*);

//--- test_clock_source_and_pin_control.sv
// Purpose: Self-checking bench for the clock source and pin control block
// Assumes: Inputs change at the falling edge; sda pulled up
// Notes:   Field codes stay legal, reserved ones are never written
module test_clock_source_and_pin_control
    import clock_source_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 80000;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        ctrlPinZero = 1'b1;
    logic        ctrlPinOne = 1'b1;
    logic        sscBypass = 1'b0;
    logic        sclOut, sdaRel, sdaOut, sdaOe, pllPowerDown, refInputBSel;
    logic        inputStagePowerDown, spreadPowerDown, spreadForceLow;
    logic        pll2PlainEnable, pllDividerBypass;
    logic        outputsTristate, outputsInactive;
    logic [2:0]  vcoHighSpeed;
    logic [17:0] dividerSourceSel;
    logic [1:0]  inputType;
    int          errors = 0;
    int          checkCount = 0;
    int          cycles = 0;
    logic [7:0]  ofs [5] = '{VCO_MODE_OFS, SRC_SEL_A_OFS, PIN_FUNC_OFS,
                             INPUT_CFG_OFS, POWER_CFG_OFS};
    logic [7:0]  rstVal [5] = '{VCO_MODE_RST, SRC_SEL_A_RST, PIN_FUNC_RST,
                                INPUT_CFG_RST, POWER_CFG_RST};
    wire logic   sdaLine = sdaRel & ~(sdaOe & ~sdaOut);
    wire logic [8:0] ctlSeen = {pllPowerDown, inputStagePowerDown,
        spreadPowerDown, spreadForceLow, pll2PlainEnable, pllDividerBypass,
        outputsTristate, outputsInactive, refInputBSel};

    clock_source_and_pin_control dut (
        .sclIn(sclOut), .sdaIn(sdaLine), .*
    );
    smbus_host_model host (.*);

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [17:0] seen, exp);
        checkCount++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        if (errors == 0 && checkCount > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    // Care mask in the top half: plain enable is left open while the PLLs
    // are stopped, and the spread bits too in test bypass
    function automatic logic [17:0] exp_ctl(input logic [1:0] f0, f1, it,
                                           input logic pd, pick, p0, p1, ssc);
        logic pz, byp, any;
        pz = (f0 == PIN0_POWER_DOWN) && !p0;
        byp = (f0 == PIN0_TEST_BYP) && !p0;
        any = pd | pz;
        return {byp ? 9'h18f : (any ? 9'h1ef : 9'h1ff),
                any | byp, any, ssc | any, ssc, 1'b1, byp & !pd,
                any | (f1 == PIN1_TRISTATE && !p1),
                f1 == PIN1_INACTIVE && !p1 && !any,
                it == INPUT_TWO_SE && (f0 == PIN0_CLK_PICK ? p0 : pick)};
    endfunction : exp_ctl

    task automatic pin_sweep(input logic [1:0] f0, f1, it,
                             input logic pd, pick);
        logic [17:0] em;
        logic [8:0]  m;
        for (int k = 0; k < 8; k++) begin
            {ctrlPinZero, ctrlPinOne, sscBypass} = 3'(k);
            repeat (10) @(negedge core_clk);
            em = exp_ctl(f0, f1, it, pd, pick, ctrlPinZero, ctrlPinOne,
                         sscBypass);
            m = ctlSeen & em[17:9];
            em[8:0] = em[8:0] & em[17:9];
            check("pwr", 18'(m[8:3]), 18'(em[8:3]));
            check("out", 18'(m[2:0]), 18'(em[2:0]));
        end
    endtask : pin_sweep

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            end_of_test();
        end
    end

    initial begin
        logic [7:0]  rd;
        logic [7:0]  bb [4];
        logic [7:0]  q [$];
        logic [2:0]  s [6];
        logic [17:0] ds;
        logic [1:0]  it, f0, f1;
        logic        ok, pd, pick;
        void'($urandom(41));
        repeat (12) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge core_clk);
        check("vco", 18'(vcoHighSpeed), 18'h7);
        check("div", dividerSourceSel, 18'h09262);
        check("type", 18'(inputType), 18'h0);
        pin_sweep(2'b00, 2'b00, 2'b00, 1'b0, 1'b0);
        for (int k = 0; k < 5; k++) begin
            host.bus_read(ofs[k], rd);
            check("reset byte", 18'(rd), 18'(rstVal[k]));
        end
        rd = 8'($urandom_range(0, 7)) << 5;
        q = {rd, 8'h5a, 8'ha5};
        host.bus_write(DEVICE_ADDR, VCO_MODE_OFS, q, ok);
        check("ack", 18'(ok), 18'h1);
        check("vco", 18'(vcoHighSpeed), 18'(rd[7:5]));
        host.bus_read(VCO_MODE_OFS + 8'h1, rd);
        check("unmapped", 18'(rd), 18'h0);
        q = {8'h00};
        host.bus_write(DEVICE_ADDR + 7'h1, SRC_SEL_A_OFS, q, ok);
        check("bad addr", 18'(ok), 18'h0);
        check("div", dividerSourceSel, 18'h09262);
        for (int i = 0; i < 12; i++) begin
            f0 = 2'(i % 3);
            f1 = 2'((i / 3) % 2);
            pd = 1'((i / 6) % 2);
            it = 2'((i + i / 3) % 3);
            pick = 1'($urandom_range(0, 1));
            foreach (s[j]) s[j] = 3'($urandom_range(0, 4));
            bb = '{{2'b00, s[0], s[1]}, {f0, 1'b0, pick, f1, 2'b00},
                   {it, s[2], s[3]}, {1'b0, pd, s[4], s[5]}};
            q = {bb[0], bb[1], bb[2], bb[3]};
            ds = {s[5], s[4], s[3], s[2], s[1], s[0]};
            host.bus_write(DEVICE_ADDR, SRC_SEL_A_OFS, q, ok);
            check("ack", 18'(ok), 18'h1);
            check("div", dividerSourceSel, ds);
            check("type", 18'(inputType), 18'(it));
            host.bus_read(SRC_SEL_A_OFS + 8'(i % 4), rd);
            check("readback", 18'(rd), 18'(bb[i % 4]));
            pin_sweep(f0, f1, it, pd, pick);
        end
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge core_clk);
        check("div", dividerSourceSel, 18'h09262);
        check("vco", 18'(vcoHighSpeed), 18'h7);
        end_of_test();
    end
endmodule : test_clock_source_and_pin_control
